// File: hdl/ffq_pkg.sv
// Package: constants and register map of the load/unload queue stack
package ffq_pkg;

    // Storage geometry
    localparam int DEPTH_WORD = 128;           // Word stack capacity
    localparam int DEPTH_LONG = 64;            // Long-word stack capacity
    localparam int IDX_W = 7;                  // Element index width
    localparam int POS_W = 8;                  // Position width, holds 0..128
    localparam int DATA_W = 32;                // Element storage width
    localparam int ADDR_W = 12;                // APB address width

    // Printed control element word indices; byte address is four times
    localparam int REG_STATUS_IDX = 0;
    localparam int REG_LENGTH_IDX = 1;
    localparam int REG_POSITION_IDX = 2;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h000;
    localparam logic [ADDR_W-1:0] ADDR_LENGTH = 12'h004;
    localparam logic [ADDR_W-1:0] ADDR_POSITION = 12'h008;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h00c;
    localparam logic [ADDR_W-1:0] ADDR_SOURCE = 12'h010;
    localparam logic [ADDR_W-1:0] ADDR_DEST = 12'h014;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 12'h018;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 12'h01c;
    localparam logic [ADDR_W-1:0] ADDR_STACK_BASE = 12'h200;

    // Status word bit positions
    localparam int EN_BIT = 15;
    localparam int UNLOAD_EN_BIT = 14;
    localparam int FULL_BIT = 13;
    localparam int EMPTY_BIT = 12;

    // Control register bit positions
    localparam int CTRL_LOAD_RUNG = 0;
    localparam int CTRL_UNLOAD_RUNG = 1;
    localparam int CTRL_LONG_MODE = 2;

    // Interrupt status bit positions
    localparam int IRQ_LOADED = 0;
    localparam int IRQ_UNLOADED = 1;
    localparam int IRQ_FULL = 2;
    localparam int IRQ_REFUSED = 3;
    localparam int IRQ_W = 4;

    // Values after reset
    localparam logic [15:0] LENGTH_RST = 16'h0001;
    localparam logic [POS_W-1:0] POSITION_RST = 8'h00;
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
    localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;

endpackage

// File: hdl/ffq_store_if.sv
// Interface between the queue controller and its element storage
`timescale 1ns/1ps
`default_nettype none
interface ffq_store_if;
    import ffq_pkg::*;
    logic push;                      // Write wdata at wr_idx
    logic pop;                       // Shift toward base, zero last_idx
    logic [IDX_W-1:0] wr_idx;        // Load target slot
    logic [IDX_W-1:0] last_idx;      // Final slot of configured stack
    logic [IDX_W-1:0] rd_idx;        // Software read slot
    logic [DATA_W-1:0] wdata;        // Loaded value
    logic [DATA_W-1:0] head;         // Element at position zero
    logic [DATA_W-1:0] rd_data;      // Element at rd_idx

    modport ctrl (
        output push, pop, wr_idx, last_idx, rd_idx, wdata,
        input head, rd_data
    );
    modport mem (
        input push, pop, wr_idx, last_idx, rd_idx, wdata,
        output head, rd_data
    );
endinterface
`default_nettype wire

// File: hdl/ffq_store.sv
// Element storage of the queue stack with shift-toward-base on unload
`timescale 1ns/1ps
`default_nettype none
module ffq_store (
    input wire logic mclk,
    input wire logic srst,
    ffq_store_if.mem st
);
    import ffq_pkg::*;

    // One element per slot, base at slot zero
    logic [DATA_W-1:0] mem_q [DEPTH_WORD];

    // Each slot decides its own next value; push and pop never coincide
    for (genvar i = 0; i < DEPTH_WORD; i++) begin : g_slot
        always_ff @(posedge mclk) begin
            if (srst) begin
                mem_q[i] <= DATA_RST;
            end else if (st.pop) begin
                if (IDX_W'(i) == st.last_idx) begin
                    mem_q[i] <= DATA_RST;            // [RULE13]
                end else if (IDX_W'(i) < st.last_idx) begin
                    if (i < DEPTH_WORD - 1) begin
                        mem_q[i] <= mem_q[(i + 1) % DEPTH_WORD]; // [RULE13]
                    end
                end
            end else if (st.push && IDX_W'(i) == st.wr_idx) begin
                mem_q[i] <= st.wdata;                // [RULE1] [RULE5]
            end
        end
    end

    // Oldest entry sits at the base
    assign st.head = mem_q[0];                       // [RULE12]
    assign st.rd_data = mem_q[st.rd_idx];
endmodule
`default_nettype wire

// File: hdl/ffq_top.sv
// Queue stack top: APB registers, rung edge logic, load and unload control
//
// Overview of operation
// RULE1: Load rung rising edge writes source at position
// RULE2: Program keeps source within element size range
// RULE3: Stack occupies consecutive slots from its base
// RULE4: Control element: status, length, position words
// RULE5: Position selects next slot to be loaded
// RULE6: Load enable bit 15 set on rung rise
// RULE7: Full bit 13 when count reaches length
// RULE8: Empty bit 12 when stack holds nothing
// RULE9: Program keeps length 1..128 word, 1..64 long
// RULE10: Position kept within element range
// RULE11: Each completed load increments position
// RULE12: Unload rung rise copies base element out
// RULE13: Unload shifts elements down, zeroes last
// RULE14: Each completed unload decrements position
// RULE15: Unload enable bit 14 set on rung rise
// RULE16: Program uses destination of element size
// RULE17: No load when full, no unload when empty
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ffq_top (
    input wire logic mclk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ffq_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq
);
    import ffq_pkg::*;

    // Software-visible state
    logic [15:0] length_q;            // Configured stack length
    logic [POS_W-1:0] pos_q;          // Next slot to load, also the count
    logic [2:0] ctrl_q;               // Rung levels and element size
    logic [DATA_W-1:0] src_q;         // Source operand
    logic [DATA_W-1:0] dest_q;        // Destination operand
    logic [IRQ_W-1:0] irq_stat_q;     // Sticky event bits
    logic [IRQ_W-1:0] irq_mask_q;     // Enables for irq
    logic en_q;                       // Load enable flag
    logic unload_en_q;                // Unload enable flag

    // Rung edge detection
    logic load_rung_prev_q;           // Load rung one cycle back
    logic unload_rung_prev_q;         // Unload rung one cycle back
    logic unload_pend_q;              // Unload held over a shared cycle

    // Bus answer and interrupt registers
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic irq_q;

    // Derived control
    logic long_mode;
    logic [POS_W-1:0] depth_lim;      // Slot count of current element size
    logic [POS_W-1:0] eff_len;        // Length limited to storage
    logic full_flag;
    logic empty_flag;
    logic load_rise;
    logic unload_rise;
    logic do_load;
    logic do_unload;
    logic unload_req;
    logic [15:0] status_word;
    logic [DATA_W-1:0] src_sized;

    // Bus decode
    logic acc;                        // Access phase, not yet answered
    logic wr_acc;
    logic stack_hit;
    logic known;
    logic [IDX_W-1:0] stack_idx;

    ffq_store_if st ();

    ffq_store u_store (
        .mclk(mclk),
        .srst(srst),
        .st(st)
    );

    // Element size picks the storage depth
    assign long_mode = ctrl_q[CTRL_LONG_MODE];
    assign depth_lim = long_mode ? POS_W'(DEPTH_LONG) : POS_W'(DEPTH_WORD);

    // A length outside 1..depth would run off the storage; limit it here
    always_comb begin
        if (length_q == 16'h0000) begin
            eff_len = 8'h01;                                 // [RULE9]
        end else if (length_q > 16'(depth_lim)) begin
            eff_len = depth_lim;                             // [RULE9]
        end else begin
            eff_len = length_q[POS_W-1:0];
        end
    end

    // Flags follow the live count, so they are right after any write
    assign full_flag = (pos_q >= eff_len);                   // [RULE7]
    assign empty_flag = (pos_q == POSITION_RST);             // [RULE8]

    // Status word layout; low bits unused and read as zero
    always_comb begin
        status_word = 16'h0000;
        status_word[EN_BIT] = en_q;                          // [RULE4]
        status_word[UNLOAD_EN_BIT] = unload_en_q;
        status_word[FULL_BIT] = full_flag;
        status_word[EMPTY_BIT] = empty_flag;
    end

    // Rung transitions from false to true start the operations
    assign load_rise = ctrl_q[CTRL_LOAD_RUNG] && !load_rung_prev_q;
    assign unload_rise = ctrl_q[CTRL_UNLOAD_RUNG] && !unload_rung_prev_q;

    // Load wins a shared cycle; the unload then runs one cycle later
    assign unload_req = unload_rise || unload_pend_q;
    assign do_load = load_rise && !full_flag;                // [RULE17]
    assign do_unload = unload_req && !load_rise && !empty_flag; // [RULE17]

    // Word stacks keep only the low half of the source
    assign src_sized = long_mode ? src_q : {16'h0000, src_q[15:0]}; // [RULE2]

    // Storage requests
    assign st.push = do_load;
    assign st.pop = do_unload;
    assign st.wr_idx = pos_q[IDX_W-1:0];                     // [RULE5]
    assign st.wdata = src_sized;                             // [RULE1]
    assign st.last_idx = IDX_W'(eff_len - 8'h01);            // [RULE13]
    assign st.rd_idx = stack_idx;

    // APB decode
    assign acc = psel && penable && !pready_q;
    assign wr_acc = acc && pwrite;
    assign stack_hit = (paddr >= ADDR_STACK_BASE)
        && (paddr < ADDR_STACK_BASE + ADDR_W'(4 * DEPTH_WORD));
    assign stack_idx = paddr[IDX_W+1:2];                     // [RULE3]
    always_comb begin
        case (paddr)
            ADDR_STATUS, ADDR_LENGTH, ADDR_POSITION, ADDR_CTRL,
            ADDR_SOURCE, ADDR_DEST, ADDR_IRQ_STAT, ADDR_IRQ_MASK: begin
                known = 1'b1;
            end
            default: begin
                known = stack_hit && (paddr[1:0] == 2'b00);
            end
        endcase
    end

    // Edge history of both rungs
    always_ff @(posedge mclk) begin
        if (srst) begin
            load_rung_prev_q <= 1'b0;
            unload_rung_prev_q <= 1'b0;
        end else begin
            load_rung_prev_q <= ctrl_q[CTRL_LOAD_RUNG];
            unload_rung_prev_q <= ctrl_q[CTRL_UNLOAD_RUNG];
        end
    end

    // An unload that met a load is kept for the next cycle
    always_ff @(posedge mclk) begin
        if (srst) begin
            unload_pend_q <= 1'b0;
        end else begin
            unload_pend_q <= unload_rise && load_rise;
        end
    end

    // Enable flags set on the rising rung, drop when the rung goes false
    always_ff @(posedge mclk) begin
        if (srst) begin
            en_q <= 1'b0;
            unload_en_q <= 1'b0;
        end else begin
            if (load_rise) begin
                en_q <= 1'b1;                                // [RULE6]
            end else if (!ctrl_q[CTRL_LOAD_RUNG]) begin
                en_q <= 1'b0;
            end
            if (unload_rise) begin
                unload_en_q <= 1'b1;                         // [RULE15]
            end else if (!ctrl_q[CTRL_UNLOAD_RUNG]) begin
                unload_en_q <= 1'b0;
            end
        end
    end

    // Position: hardware steps win over a software write in the same cycle
    always_ff @(posedge mclk) begin
        if (srst) begin
            pos_q <= POSITION_RST;
        end else if (do_load) begin
            pos_q <= pos_q + 8'h01;                          // [RULE11]
        end else if (do_unload) begin
            pos_q <= pos_q - 8'h01;                          // [RULE14]
        end else if (wr_acc && paddr == ADDR_POSITION) begin
            if (pwdata[15:0] > 16'(eff_len)) begin
                pos_q <= eff_len;                            // [RULE10]
            end else begin
                pos_q <= pwdata[POS_W-1:0];
            end
        end
    end

    // Length word
    always_ff @(posedge mclk) begin
        if (srst) begin
            length_q <= LENGTH_RST;
        end else if (wr_acc && paddr == ADDR_LENGTH) begin
            length_q <= pwdata[15:0];                        // [RULE4]
        end
    end

    // Control and source operands
    always_ff @(posedge mclk) begin
        if (srst) begin
            ctrl_q <= CTRL_RST;
            src_q <= DATA_RST;
        end else begin
            if (wr_acc && paddr == ADDR_CTRL) begin
                ctrl_q <= pwdata[2:0];
            end
            if (wr_acc && paddr == ADDR_SOURCE) begin
                src_q <= pwdata;
            end
        end
    end

    // Destination takes the oldest element on an unload
    always_ff @(posedge mclk) begin
        if (srst) begin
            dest_q <= DATA_RST;
        end else if (do_unload) begin
            dest_q <= long_mode ? st.head
                : {16'h0000, st.head[15:0]};                 // [RULE12] [RULE16]
        end
    end

    // Sticky events; a set in the clearing cycle survives the clear
    always_ff @(posedge mclk) begin
        if (srst) begin
            irq_stat_q <= IRQ_RST;
        end else begin
            for (int b = 0; b < IRQ_W; b++) begin
                if (wr_acc && paddr == ADDR_IRQ_STAT && pwdata[b]) begin
                    irq_stat_q[b] <= 1'b0;
                end
            end
            if (do_load) begin
                irq_stat_q[IRQ_LOADED] <= 1'b1;
            end
            if (do_unload) begin
                irq_stat_q[IRQ_UNLOADED] <= 1'b1;
            end
            if (do_load && pos_q + 8'h01 == eff_len) begin
                irq_stat_q[IRQ_FULL] <= 1'b1;
            end
            if ((load_rise && full_flag)
                || (unload_req && !load_rise && empty_flag)) begin
                irq_stat_q[IRQ_REFUSED] <= 1'b1;             // [RULE17]
            end
        end
    end

    // Interrupt mask
    always_ff @(posedge mclk) begin
        if (srst) begin
            irq_mask_q <= IRQ_RST;
        end else if (wr_acc && paddr == ADDR_IRQ_MASK) begin
            irq_mask_q <= pwdata[IRQ_W-1:0];
        end
    end

    // Level interrupt, registered so the pin is glitch free
    always_ff @(posedge mclk) begin
        if (srst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    // APB answer: one wait state, so every answer comes from a flip-flop
    always_ff @(posedge mclk) begin
        if (srst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= acc;
            pslverr_q <= acc && !known;
            prdata_q <= 32'h0000_0000;
            if (acc && !pwrite) begin
                case (paddr)
                    ADDR_STATUS: begin
                        prdata_q <= {16'h0000, status_word};
                    end
                    ADDR_LENGTH: begin
                        prdata_q <= {16'h0000, length_q};
                    end
                    ADDR_POSITION: begin
                        prdata_q <= {24'h00_0000, pos_q};
                    end
                    ADDR_CTRL: begin
                        prdata_q <= {29'h0000_0000, ctrl_q};
                    end
                    ADDR_SOURCE: begin
                        prdata_q <= src_q;
                    end
                    ADDR_DEST: begin
                        prdata_q <= dest_q;
                    end
                    ADDR_IRQ_STAT: begin
                        prdata_q <= {28'h000_0000, irq_stat_q};
                    end
                    ADDR_IRQ_MASK: begin
                        prdata_q <= {28'h000_0000, irq_mask_q};
                    end
                    default: begin
                        // Stack window; unmapped reads return zero
                        if (known) begin
                            prdata_q <= st.rd_data;          // [RULE3]
                        end
                    end
                endcase
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;

endmodule
`default_nettype wire

// File: bench/ffq_chk.sv
// Checker of APB handshake and address map of the queue stack
`timescale 1ns/1ps
`default_nettype none
module ffq_chk (
    input wire logic mclk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ffq_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq
);
    import ffq_pkg::*;
    // Access phase of the master
    logic acc;
    assign acc = psel && penable;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    // Answer lasts one cycle only
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held");
    // Exactly one wait state
    ready_wait_a: assert property (acc && !pready |=> pready)
        else $error("pready late");
    // No answer outside an access
    ready_acc_a: assert property (pready |-> acc)
        else $error("pready outside access");
    // Read data quiet between answers
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr alone");
    // Hole between registers and stack window
    gap_err_a: assert property (pready && paddr >= 12'h020
        && paddr < 12'h200 |-> pslverr) else $error("gap not refused");
    reg_okay_a: assert property (pready && paddr < 12'h020
        && paddr[1:0] == 2'h0 |-> !pslverr) else $error("reg refused");
    // Aligned stack slots answer OKAY, others do not
    stack_okay_a: assert property (pready && paddr >= 12'h200
        && paddr < 12'h400 |-> pslverr == (paddr[1:0] != 2'h0))
        else $error("stack response wrong");
endmodule
bind ffq_top ffq_chk chk_u (.mclk(mclk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
`default_nettype wire

// File: bench/ffq_prog.sv
// Controller program model: APB master issuing operands and rungs
`timescale 1ns/1ps
`default_nettype none
module ffq_prog (
    input wire logic mclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [ffq_pkg::ADDR_W-1:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready
);
    import ffq_pkg::*;
    // Idle bus from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
    end
    // One transfer; held until pready is sampled high
    // Callers keep sources and destinations at element size
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule
`default_nettype wire

// File: bench/tb_ffq_top.sv
// Self-checking bench of the queue stack
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module tb_ffq_top;
    import ffq_pkg::*;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    wire logic psel, penable, pwrite, pready, pslverr, irq;
    wire logic [ADDR_W-1:0] paddr;
    wire logic [31:0] pwdata, prdata;
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [31:0] rv;
    logic lm = 1'b0; // Long mode bit kept in every rung write
    logic [31:0] v [3] = '{32'h0000_8000, 32'h0000_7fff, 32'h0000_1234};
    always #12.5 mclk = ~mclk;
    ffq_top dut_u (.mclk(mclk), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq));
    ffq_prog prog_u (.mclk(mclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready));
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        prog_u.xfer(1'b1, a, d, rv);
    endtask
    // Read one register and compare
    task automatic chk_rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        prog_u.xfer(1'b0, a, 32'h0, rv);
        `CHK(rv, e)
    endtask
    // Rung bits: b0 load, b1 unload; raised then dropped
    task automatic pulse(input logic [1:0] b);
        wr(ADDR_CTRL, {29'h0, lm, b});
        wr(ADDR_CTRL, {29'h0, lm, 2'b00});
    endtask
    // Expected status word from element count and length
    function automatic logic [31:0] st(int p, int l, bit en, bit eu);
        return {16'h0, en, eu, p == l, p == 0, 12'h0};
    endfunction
    task automatic t_reset();
        chk_rd(ADDR_STATUS, 32'h0000_1000);
        chk_rd(ADDR_LENGTH, 32'h1);
        chk_rd(ADDR_POSITION, 32'h0);
        chk_rd(12'h100, 32'h0);
        `CHK(pslverr, 1'b1)
        chk_rd(12'h202, 32'h0);
        `CHK(pslverr, 1'b1)
        chk_rd(ADDR_STACK_BASE, 32'h0);
        `CHK(pslverr, 1'b0)
    endtask
    // Fill a three-deep word stack, overfill, drain, overdrain
    task automatic t_word();
        wr(ADDR_LENGTH, 32'h3);
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_SOURCE, v[i]);
            wr(ADDR_CTRL, 32'h1);
            chk_rd(ADDR_STATUS, st(i + 1, 3, 1, 0));
            wr(ADDR_CTRL, 32'h0);
            chk_rd(ADDR_POSITION, i + 1);
            chk_rd(ADDR_STACK_BASE + 4 * i, v[i]);
        end
        wr(ADDR_SOURCE, 32'h0000_5555);
        pulse(2'b01);
        chk_rd(ADDR_POSITION, 32'h3);
        chk_rd(ADDR_STACK_BASE + 8, v[2]);
        chk_rd(ADDR_IRQ_STAT, 32'hd);
        wr(ADDR_IRQ_STAT, 32'hf);
        chk_rd(ADDR_IRQ_STAT, 32'h0);
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_CTRL, 32'h2);
            chk_rd(ADDR_STATUS, st(2 - i, 3, 0, 1));
            wr(ADDR_CTRL, 32'h0);
            chk_rd(ADDR_DEST, v[i]);
            chk_rd(ADDR_POSITION, 2 - i);
            chk_rd(ADDR_STACK_BASE + 8, 32'h0);
            if (i < 2) begin
                chk_rd(ADDR_STACK_BASE, v[i + 1]);
            end
        end
        pulse(2'b10);
        chk_rd(ADDR_DEST, v[2]);
        chk_rd(ADDR_POSITION, 32'h0);
        chk_rd(ADDR_IRQ_STAT, 32'ha);
        wr(ADDR_IRQ_STAT, 32'hf);
    endtask
    // Long stack: position clamp and load into the last slot
    task automatic t_long();
        lm = 1'b1;
        wr(ADDR_CTRL, 32'h4);
        wr(ADDR_LENGTH, 32'd64);
        wr(ADDR_POSITION, 32'd100);
        chk_rd(ADDR_POSITION, 32'd64);
        wr(ADDR_POSITION, 32'd63);
        chk_rd(ADDR_STATUS, st(63, 64, 0, 0));
        wr(ADDR_SOURCE, 32'h8000_0000);
        pulse(2'b01);
        chk_rd(ADDR_STACK_BASE + 12'h0fc, 32'h8000_0000);
        chk_rd(ADDR_STATUS, st(64, 64, 0, 0));
        wr(ADDR_IRQ_STAT, 32'hf);
    endtask
    // Load event raises irq only when unmasked; W1C drops it
    task automatic t_irq();
        wr(ADDR_POSITION, 32'h0);
        wr(ADDR_IRQ_MASK, 32'h1);
        pulse(2'b01);
        `CHK(irq, 1'b1)
        wr(ADDR_IRQ_STAT, 32'h1);
        chk_rd(ADDR_IRQ_MASK, 32'h1);
        `CHK(irq, 1'b0)
        wr(ADDR_IRQ_MASK, 32'h0);
        pulse(2'b01);
        chk_rd(ADDR_IRQ_STAT, 32'h1);
        `CHK(irq, 1'b0)
    endtask
    // Both rungs rise at once on an empty stack: the load must go first,
    // or the unload would be refused and the loaded value stay behind
    task automatic t_both();
        wr(ADDR_POSITION, 32'h0);
        wr(ADDR_SOURCE, 32'h1234_5678);
        pulse(2'b11);
        chk_rd(ADDR_POSITION, 32'h0);
        chk_rd(ADDR_DEST, 32'h1234_5678);
        chk_rd(ADDR_IRQ_STAT, 32'h3);
        chk_rd(ADDR_STATUS, st(0, 64, 0, 0));
    endtask
    task automatic print_verdict();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Hang guard, far above the few hundred cycles needed
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            error_cnt++;
            print_verdict();
        end
    end
    initial begin
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        t_reset();
        t_word();
        t_long();
        t_irq();
        t_both();
        print_verdict();
    end
endmodule
`default_nettype wire
